// >>> src/ottu_pkg.sv
// constants, modes and run states for the trace trigger unit
package ottu_pkg;
  localparam logic [3:0] OFS_CAH = 4'h0;
  localparam logic [3:0] OFS_CAL = 4'h1;
  localparam logic [3:0] OFS_CBH = 4'h2;
  localparam logic [3:0] OFS_CBL = 4'h3;
  localparam logic [3:0] OFS_FH  = 4'h4;
  localparam logic [3:0] OFS_FL  = 4'h5;
  localparam logic [3:0] OFS_CTL = 4'h6;
  localparam logic [3:0] OFS_TRG = 4'h7;
  localparam logic [3:0] OFS_STS = 4'h8;
  localparam int CTL_EN    = 7;
  localparam int CTL_ARM   = 6;
  localparam int CTL_TAG   = 5;
  localparam int CTL_BRK   = 4;
  localparam int CTL_RWA   = 3;
  localparam int CTL_CMP_A_DIRECTION_QUALIFY = 2;
  localparam int CTL_RWB   = 1;
  localparam int CTL_CMP_B_DIRECTION_QUALIFY = 0;
  localparam int TRG_TSEL  = 7;
  localparam int TRG_BEGIN = 6;
  localparam int STS_AF    = 7;
  localparam int STS_BF    = 6;
  localparam int STS_RUN_ACTIVE_FLAG  = 5;
  localparam logic [7:0] CMP_RST   = 8'h00;
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] TRG_RST   = 8'h00;
  localparam logic [7:0] TRG_WMASK = 8'hCF;
  localparam logic [7:0] RD_ZERO   = 8'h00;
  localparam logic [3:0] MODE_A_ONLY  = 4'h0;
  localparam logic [3:0] MODE_A_OR_B  = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVT_B   = 4'h3;
  localparam logic [3:0] MODE_A_EVT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_D = 4'h5;
  localparam logic [3:0] MODE_A_NOT_D = 4'h6;
  localparam logic [3:0] MODE_INSIDE  = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] CNT_FULL = 4'h8;
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_SEEK = 3'b010,
    RS_FILL = 3'b100
  } ottu_run_e;
  function automatic logic ottu_event_only(input logic [3:0] m);
    return (m == MODE_EVT_B) || (m == MODE_A_EVT_B);
  endfunction : ottu_event_only
endpackage : ottu_pkg

// >>> src/ottu_cmp.sv
// one 16-bit address comparator with direction qualification
`timescale 1ns/10ps
module ottu_cmp (
  input  wire logic [15:0] value,
  input  wire logic [15:0] addr,
  input  wire logic        valid,
  input  wire logic        rw,
  input  wire logic        qual,
  input  wire logic        dir,
  output logic             hit,
  output logic             below,
  output logic             above
);
  logic dir_ok;
  // direction ignored unless qualified; rw high is a read
  assign dir_ok = !qual || (rw == dir);
  // full 16-bit equality only
  assign hit   = valid && dir_ok && (addr == value);
  assign below = valid && (addr < value);
  assign above = valid && (addr > value);
endmodule : ottu_cmp

// >>> src/ottu_fifo.sv
// eight-word shift fifo, head is the oldest word
`timescale 1ns/10ps
module ottu_fifo (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        shift_en,
  input  wire logic [15:0] shift_data,
  output logic      [15:0] head
);
  logic [15:0] mem [ottu_pkg::FIFO_DEPTH];
  // a shift moves every word toward the head and fills the last slot
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < ottu_pkg::FIFO_DEPTH; i++) begin
        mem[i] <= 16'h0000;
      end
    end else if (shift_en) begin
      for (int i = 0; i < ottu_pkg::FIFO_DEPTH - 1; i++) begin
        mem[i] <= mem[i+1];
      end
      mem[ottu_pkg::FIFO_DEPTH-1] <= shift_data;
    end
  end
  assign head = mem[0];
endmodule : ottu_fifo

// >>> src/ottu_top.sv
// trace trigger unit: registers, trigger logic, run control, breaks
//
// Functional notes
// [R1] comparator bytes reset to zero, always readable, written only when idle
// [R2] nine bytes: comparators A, B, fifo word, control, trigger, status
// [R3] registers reached by plain program accesses on the register port
// [R4] fifo high port returns head bits 15:8, writes ignored
// [R5] event-only modes store data in low byte, high byte zero
// [R6] high read keeps fifo position, low read advances it
// [R7] reader takes high byte before low byte; low only for events
// [R8] low reads while armed do not advance the fifo
// [R9] low read when idle stores last fetched opcode address at fifo tail
// [R10] ninth profiling read returns first read's sample, eight deep
// [R11] control register readable and writable at any time
// [R12] bit 7 enables unit, cannot be set while secured
// [R13] arm write sets arm and flag; run end or clears stop it
// [R14] bit 5 picks tag or force breaks, only when breaks enabled
// [R15] breaks on trigger in end trace, on fifo full in begin trace
// [R16] with breaks off, triggers still store into fifo
// [R17] bits 3:2 qualify comparator A by direction
// [R18] bits 1:0 qualify comparator B by direction
// [R19] trigger qualification does not alter break timing
// [R20] four-bit mode selects nine modes; codes 9 to 15 never trigger
// [R21] run ends on full in begin trace or trigger in end trace
// [R22] begin or end trace select; event-only always begin
// [R23] valid count cleared at start, saturates at 8, reads do not lower
// [R24] eight 16-bit fifo words, comparators match full 16 bits
// [R25] no match, storage or break while the unit is disabled
`timescale 1ns/10ps
module ottu_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        mcu_secure,
  input  wire logic        bus_valid,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rw,
  input  wire logic [7:0]  bus_data,
  input  wire logic        bus_fetch,
  input  wire logic        exec_valid,
  input  wire logic [15:0] exec_addr,
  input  wire logic        cof_valid,
  input  wire logic [15:0] cof_addr,
  output logic             break_req,
  output logic             break_is_tag
);
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [7:0]  ctl_reg;
  logic [7:0]  trg_reg;
  logic [3:0]  cnt_reg;
  logic        af_reg;
  logic        bf_reg;
  logic        a_seen_reg;
  logic [15:0] last_op_reg;
  ottu_pkg::ottu_run_e run_reg;
  ottu_pkg::ottu_run_e run_next;
  logic        en;
  logic        armed;
  logic        en_new;
  logic        ctl_wr;
  logic        start;
  logic        stop;
  logic        evt_only;
  logic        begin_tr;
  logic [3:0]  mode;
  logic [15:0] q_addr;
  logic        q_valid;
  logic        q_rw;
  logic        hit_a;
  logic        hit_b;
  logic        below_a;
  logic        above_a;
  logic        below_b;
  logic        above_b;
  logic        data_b;
  logic        in_range;
  logic        trig;
  logic        evt_hit;
  logic        push;
  logic        pop;
  logic        fill_done;
  logic        brk_pulse;
  logic        shift_en;
  logic [15:0] shift_data;
  logic [15:0] head;

  assign en       = ctl_reg[ottu_pkg::CTL_EN];
  assign armed    = run_reg != ottu_pkg::RS_IDLE;
  assign mode     = trg_reg[3:0];
  assign evt_only = ottu_pkg::ottu_event_only(mode);
  // event-only runs are always begin traces
  assign begin_tr = trg_reg[ottu_pkg::TRG_BEGIN] || evt_only; // see [R22]
  assign ctl_wr   = reg_wr && (reg_addr == ottu_pkg::OFS_CTL); // see [R11]
  // a secured part can never turn the unit on
  assign en_new   = reg_wdata[ottu_pkg::CTL_EN] && !mcu_secure; // see [R12]
  assign start    = ctl_wr && en_new && !armed &&
                    reg_wdata[ottu_pkg::CTL_ARM]; // see [R13]
  assign stop     = armed && (!en || (ctl_wr &&
                    (!en_new || !reg_wdata[ottu_pkg::CTL_ARM])));

  // tag qualification swaps in the executed-opcode address; it only
  // changes what matches, never when a break fires
  assign q_addr  = trg_reg[ottu_pkg::TRG_TSEL] ? exec_addr : bus_addr;
  assign q_valid = (trg_reg[ottu_pkg::TRG_TSEL] ? exec_valid : bus_valid)
                   && en && armed; // see [R25]
  assign q_rw    = trg_reg[ottu_pkg::TRG_TSEL] ? 1'b1 : bus_rw;

  ottu_cmp u_cmp_a (
    .value (cmp_a_reg),
    .addr  (q_addr),
    .valid (q_valid),
    .rw    (q_rw),
    .qual  (ctl_reg[ottu_pkg::CTL_CMP_A_DIRECTION_QUALIFY]),
    .dir   (ctl_reg[ottu_pkg::CTL_RWA]),
    .hit   (hit_a),
    .below (below_a),
    .above (above_a)
  ); // see [R17] see [R24]

  ottu_cmp u_cmp_b (
    .value (cmp_b_reg),
    .addr  (q_addr),
    .valid (q_valid),
    .rw    (q_rw),
    .qual  (ctl_reg[ottu_pkg::CTL_CMP_B_DIRECTION_QUALIFY]),
    .dir   (ctl_reg[ottu_pkg::CTL_RWB]),
    .hit   (hit_b),
    .below (below_b),
    .above (above_b)
  ); // see [R18]

  assign data_b   = bus_data == cmp_b_reg[7:0];
  assign in_range = q_valid && !below_a && !above_b;

  always_comb begin
    trig    = 1'b0;
    evt_hit = 1'b0;
    case (mode) // see [R20]
      ottu_pkg::MODE_A_ONLY:   trig = hit_a;
      ottu_pkg::MODE_A_OR_B:   trig = hit_a || hit_b;
      ottu_pkg::MODE_A_THEN_B: trig = hit_b && a_seen_reg;
      ottu_pkg::MODE_EVT_B:    evt_hit = hit_b;
      ottu_pkg::MODE_A_EVT_B:  evt_hit = hit_b && a_seen_reg;
      ottu_pkg::MODE_A_AND_D:  trig = hit_a && data_b;
      ottu_pkg::MODE_A_NOT_D:  trig = hit_a && !data_b;
      ottu_pkg::MODE_INSIDE:   trig = in_range;
      ottu_pkg::MODE_OUTSIDE:  trig = q_valid && (below_a || above_b);
      default:                 trig = 1'b0;
    endcase
  end

  // storage happens whether or not breaks are enabled
  always_comb begin
    push = 1'b0;
    case (run_reg) // see [R16]
      ottu_pkg::RS_SEEK: push = !begin_tr && cof_valid && en;
      ottu_pkg::RS_FILL: push = en && (evt_only ? evt_hit : cof_valid);
      default:           push = 1'b0;
    endcase
  end

  // armed low reads are frozen; an idle low read profiles the cpu
  assign pop = reg_rd && (reg_addr == ottu_pkg::OFS_FL) && !armed
               && en; // see [R6] see [R8] see [R9]
  assign fill_done = (run_reg == ottu_pkg::RS_FILL) && push &&
                     (cnt_reg == ottu_pkg::CNT_FULL - 4'h1);
  assign shift_en   = push || pop;
  assign shift_data = pop ? last_op_reg :
                      evt_only ? {8'h00, bus_data} : cof_addr; // see [R5]

  ottu_fifo u_fifo (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .shift_en   (shift_en),
    .shift_data (shift_data),
    .head       (head)
  ); // see [R10] see [R24]

  always_comb begin
    run_next = run_reg;
    case (run_reg)
      ottu_pkg::RS_IDLE: begin
        if (start) begin
          run_next = evt_only ? ottu_pkg::RS_FILL : ottu_pkg::RS_SEEK;
        end
      end
      ottu_pkg::RS_SEEK: begin
        if (stop) begin
          run_next = ottu_pkg::RS_IDLE;
        end else if (trig) begin
          run_next = begin_tr ? ottu_pkg::RS_FILL
                              : ottu_pkg::RS_IDLE; // see [R21]
        end
      end
      ottu_pkg::RS_FILL: begin
        if (stop || fill_done) begin
          run_next = ottu_pkg::RS_IDLE; // see [R21]
        end
      end
      default: run_next = ottu_pkg::RS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_reg <= ottu_pkg::RS_IDLE;
    end else begin
      run_reg <= run_next; // see [R13]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmp_a_reg <= {ottu_pkg::CMP_RST, ottu_pkg::CMP_RST};
      cmp_b_reg <= {ottu_pkg::CMP_RST, ottu_pkg::CMP_RST}; // see [R1]
    end else if (reg_wr && !armed) begin
      case (reg_addr) // see [R1] see [R3]
        ottu_pkg::OFS_CAH: cmp_a_reg[15:8] <= reg_wdata;
        ottu_pkg::OFS_CAL: cmp_a_reg[7:0]  <= reg_wdata;
        ottu_pkg::OFS_CBH: cmp_b_reg[15:8] <= reg_wdata;
        ottu_pkg::OFS_CBL: cmp_b_reg[7:0]  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // arm bit lives in the run state, so only the other bits are stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl_reg <= ottu_pkg::CTL_RST;
    end else if (ctl_wr) begin
      ctl_reg <= {en_new, 1'b0, reg_wdata[5:0]}; // see [R11] see [R12]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trg_reg <= ottu_pkg::TRG_RST;
    end else if (reg_wr && !armed && reg_addr == ottu_pkg::OFS_TRG) begin
      trg_reg <= reg_wdata & ottu_pkg::TRG_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else if (start) begin
      cnt_reg <= 4'h0; // see [R23]
    end else if (push && cnt_reg != ottu_pkg::CNT_FULL) begin
      cnt_reg <= cnt_reg + 4'h1; // see [R23]
    end
  end

  // hits are gated by armed, so a start never meets a set here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      af_reg     <= 1'b0;
      bf_reg     <= 1'b0;
      a_seen_reg <= 1'b0;
    end else if (start) begin
      af_reg     <= 1'b0;
      bf_reg     <= 1'b0;
      a_seen_reg <= 1'b0;
    end else begin
      af_reg     <= af_reg || hit_a;
      bf_reg     <= bf_reg || hit_b;
      a_seen_reg <= a_seen_reg || hit_a;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_op_reg <= 16'h0000;
    end else if (bus_fetch && bus_valid) begin
      last_op_reg <= bus_addr;
    end
  end

  assign brk_pulse = en && ctl_reg[ottu_pkg::CTL_BRK] && !stop &&
                     (((run_reg == ottu_pkg::RS_SEEK) && !begin_tr && trig)
                      || fill_done); // see [R15] see [R19] see [R25]

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      break_req    <= 1'b0;
      break_is_tag <= 1'b0;
    end else begin
      break_req    <= brk_pulse;
      break_is_tag <= brk_pulse && ctl_reg[ottu_pkg::CTL_TAG]; // see [R14]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= ottu_pkg::RD_ZERO;
    end else if (reg_rd) begin
      case (reg_addr) // see [R2]
        ottu_pkg::OFS_CAH: reg_rdata <= cmp_a_reg[15:8];
        ottu_pkg::OFS_CAL: reg_rdata <= cmp_a_reg[7:0];
        ottu_pkg::OFS_CBH: reg_rdata <= cmp_b_reg[15:8];
        ottu_pkg::OFS_CBL: reg_rdata <= cmp_b_reg[7:0];
        ottu_pkg::OFS_FH:  reg_rdata <= head[15:8]; // see [R4] see [R7]
        ottu_pkg::OFS_FL:  reg_rdata <= head[7:0];
        ottu_pkg::OFS_CTL: reg_rdata <= {ctl_reg[7], armed, ctl_reg[5:0]};
        ottu_pkg::OFS_TRG: reg_rdata <= trg_reg;
        ottu_pkg::OFS_STS: reg_rdata <= {af_reg, bf_reg, armed && en,
                                         1'b0, cnt_reg};
        default:           reg_rdata <= ottu_pkg::RD_ZERO;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_arm_write;
    ctl_wr && en_new && !armed && reg_wdata[ottu_pkg::CTL_ARM];
  endsequence

  sequence s_run_cleared;
    armed && cnt_reg == 4'h0 && !af_reg && !bf_reg;
  endsequence

  a_arm_clears_run: assert property ( // see [R13]
    s_arm_write |=> s_run_cleared)
    else $error("arm write did not start a clean run");

  a_cmp_locked: assert property ( // see [R1]
    (reg_wr && armed && reg_addr <= ottu_pkg::OFS_CBL)
    |=> $stable(cmp_a_reg) && $stable(cmp_b_reg))
    else $error("comparator changed while armed");

  a_secure_block: assert property ( // see [R12]
    (ctl_wr && mcu_secure) |=> !en)
    else $error("unit enabled while secured");

  a_fill_ends_run: assert property ( // see [R21]
    fill_done |=> !armed && cnt_reg == ottu_pkg::CNT_FULL)
    else $error("full fifo did not end run");

  a_fifo_frozen: assert property ( // see [R8]
    (reg_rd && reg_addr == ottu_pkg::OFS_FL && armed && !push)
    |=> $stable(head))
    else $error("armed low read moved fifo");

  a_break_off: assert property ( // see [R25]
    !en ##1 !en |-> !break_req)
    else $error("break while disabled");

  a_break_type: assert property ( // see [R14]
    brk_pulse |=> break_req &&
                  (break_is_tag == $past(ctl_reg[ottu_pkg::CTL_TAG])))
    else $error("break type wrong");

  a_no_trigger: assert property ( // see [R20]
    (mode > ottu_pkg::MODE_OUTSIDE) |-> !trig && !evt_hit)
    else $error("reserved mode triggered");

  a_dir_a: assert property ( // see [R17]
    (hit_a && ctl_reg[ottu_pkg::CTL_CMP_A_DIRECTION_QUALIFY])
    |-> q_rw == ctl_reg[ottu_pkg::CTL_RWA])
    else $error("comparator A ignored direction");

  a_count_hold: assert property ( // see [R23]
    (!armed && !start) |=> $stable(cnt_reg))
    else $error("count changed outside a run");
endmodule : ottu_top

// >>> test/ottu_cpu_model.sv
// cpu side model: bus cycles, fetches, executions, flow changes
`timescale 1ns/10ps
module ottu_cpu_model (
  input  wire logic        mclk,
  output logic             bus_valid,
  output logic      [15:0] bus_addr,
  output logic             bus_rw,
  output logic      [7:0]  bus_data,
  output logic             bus_fetch,
  output logic             exec_valid,
  output logic      [15:0] exec_addr,
  output logic             cof_valid,
  output logic      [15:0] cof_addr
);
  // kind 0 access, 1 opcode fetch, 2 execution, 3 flow change
  task automatic drive(input logic [1:0] k, input logic [15:0] a,
                       input logic rw, input logic [7:0] d);
    @(negedge mclk);
    bus_valid  = (k < 2'h2);
    bus_fetch  = (k == 2'h1);
    exec_valid = (k == 2'h2);
    cof_valid  = (k == 2'h3);
    bus_addr   = a;
    exec_addr  = a;
    cof_addr   = a;
    bus_rw     = rw;
    bus_data   = d;
    @(negedge mclk);
    // idle address and data lines carry inverted values so a stale match cannot pass
    bus_valid  = 1'b0;
    bus_fetch  = 1'b0;
    exec_valid = 1'b0;
    cof_valid  = 1'b0;
    bus_addr   = ~a;
    exec_addr  = ~a;
    cof_addr   = ~a;
    bus_data   = ~d;
  endtask : drive

  initial begin
    bus_valid  = 1'b0;
    bus_fetch  = 1'b0;
    exec_valid = 1'b0;
    cof_valid  = 1'b0;
    bus_addr   = 16'h0000;
    exec_addr  = 16'h0000;
    cof_addr   = 16'h0000;
    bus_rw     = 1'b0;
    bus_data   = 8'h00;
  end
endmodule : ottu_cpu_model

// >>> test/tb_top.sv
// self-checking bench for the trace trigger unit
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic        mclk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        mcu_secure;
  logic        bus_valid;
  logic [15:0] bus_addr;
  logic        bus_rw;
  logic [7:0]  bus_data;
  logic        bus_fetch;
  logic        exec_valid;
  logic [15:0] exec_addr;
  logic        cof_valid;
  logic [15:0] cof_addr;
  logic        break_req;
  logic        break_is_tag;
  logic        brk_tag;
  int          fails;
  int          num_checks;
  int          brk_cnt;
  int          cycles;

  ottu_top u_dut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .mcu_secure, .bus_valid, .bus_addr, .bus_rw, .bus_data,
    .bus_fetch, .exec_valid, .exec_addr, .cof_valid, .cof_addr,
    .break_req, .break_is_tag);
  ottu_cpu_model u_cpu (.mclk, .bus_valid, .bus_addr, .bus_rw, .bus_data,
    .bus_fetch, .exec_valid, .exec_addr, .cof_valid, .cof_addr);

  task automatic final_report();
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // break pulses are counted here; the ceiling cuts a hung run short
  always @(posedge mclk) begin
    cycles++;
    if (break_req === 1'b1) begin
      brk_cnt++;
      brk_tag = break_is_tag;
    end
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd   = 1'b0;
    d        = reg_rdata;
  endtask : rd

  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask : chk

  task automatic chk_run_active_flag(input logic e);
    logic [7:0] v;
    rd(ottu_pkg::OFS_STS, v);
    `CHK(v[ottu_pkg::STS_RUN_ACTIVE_FLAG], e)
  endtask : chk_run_active_flag

  function automatic logic [15:0] wd(input logic [15:0] b, input int k);
    return b + 16'(k) * 16'h0111;
  endfunction : wd

  task automatic t_regs();
    for (int i = 0; i < 9; i++) chk(4'(i), 8'h00);
    for (int i = 0; i < 4; i++) wr(4'(i), 8'hA0 + 8'(i));
    for (int i = 0; i < 4; i++) chk(4'(i), 8'hA0 + 8'(i));
    wr(ottu_pkg::OFS_FH, 8'hFF);
    wr(ottu_pkg::OFS_STS, 8'hFF);
    chk(ottu_pkg::OFS_FH, 8'h00);
    chk(ottu_pkg::OFS_STS, 8'h00);
    wr(ottu_pkg::OFS_TRG, 8'hFF);
    chk(ottu_pkg::OFS_TRG, 8'hCF);
    wr(ottu_pkg::OFS_CTL, 8'h3F);
    chk(ottu_pkg::OFS_CTL, 8'h3F);
    chk(4'hF, 8'h00);
    mcu_secure = 1'b1;
    wr(ottu_pkg::OFS_CTL, 8'h80);
    chk(ottu_pkg::OFS_CTL, 8'h00);
    mcu_secure = 1'b0;
    wr(ottu_pkg::OFS_CTL, 8'h40);
    chk(ottu_pkg::OFS_STS, 8'h00);
  endtask : t_regs

  // armed flag after access A, then after B and below A, per mode
  task automatic t_modes();
    logic [15:0] m1 = 16'h00C3;
    logic [15:0] m3 = 16'h01C7;
    wr(ottu_pkg::OFS_CAH, 8'h20);
    wr(ottu_pkg::OFS_CAL, 8'h00);
    wr(ottu_pkg::OFS_CBH, 8'h20);
    wr(ottu_pkg::OFS_CBL, 8'h10);
    for (int m = 0; m < 16; m++) begin
      wr(ottu_pkg::OFS_TRG, {4'h0, 4'(m)});
      wr(ottu_pkg::OFS_CTL, 8'hC0);
      u_cpu.drive(2'h0, 16'h2000, 1'b0, 8'h55);
      chk_run_active_flag(~m1[m]);
      u_cpu.drive(2'h0, 16'h2010, 1'b0, 8'h10);
      u_cpu.drive(2'h0, 16'h1FFF, 1'b0, 8'h00);
      chk_run_active_flag(~m3[m]);
      wr(ottu_pkg::OFS_CTL, 8'h80);
      chk_run_active_flag(1'b0);
    end
  endtask : t_modes

  task automatic t_dir();
    logic [31:0] cv = 32'hC3C1CCC4;
    for (int i = 0; i < 4; i++) begin
      wr(ottu_pkg::OFS_TRG, {7'h00, i[1]});
      wr(ottu_pkg::OFS_CTL, cv[8*i +: 8]);
      u_cpu.drive(2'h0, i[1] ? 16'h2010 : 16'h2000, ~i[0], 8'h00);
      chk_run_active_flag(1'b1);
      u_cpu.drive(2'h0, i[1] ? 16'h2010 : 16'h2000, i[0], 8'h00);
      chk_run_active_flag(1'b0);
    end
  endtask : t_dir

  // tag qualification: an access misses, the execution triggers on time
  task automatic t_tag();
    wr(ottu_pkg::OFS_TRG, 8'h80);
    wr(ottu_pkg::OFS_CTL, 8'hD0);
    u_cpu.drive(2'h0, 16'h2000, 1'b1, 8'h00);
    chk_run_active_flag(1'b1);
    u_cpu.drive(2'h2, 16'h2000, 1'b1, 8'h00);
    `CHK(break_req, 1'b1)
    chk_run_active_flag(1'b0);
  endtask : t_tag

  // begin trace: force break, tag break, then breaks off with tag set
  task automatic t_trace();
    logic [23:0] cvs = 24'hE0F0D0;
    logic [7:0]  h;
    logic [7:0]  l;
    logic [7:0]  l2;
    for (int b = 0; b < 3; b++) begin
      wr(ottu_pkg::OFS_TRG, 8'h40);
      wr(ottu_pkg::OFS_CTL, cvs[8*b +: 8]);
      brk_cnt = 0;
      u_cpu.drive(2'h3, 16'h0BAD, 1'b1, 8'h00);
      u_cpu.drive(2'h0, 16'h2000, 1'b0, 8'h00);
      for (int k = 0; k < 9; k++) begin
        if (k == 7) `CHK(brk_cnt, 0)
        // seven words in, so a head that moved would read differently
        if (b == 0 && k == 7) begin
          rd(ottu_pkg::OFS_FL, l);
          rd(ottu_pkg::OFS_FL, l2);
          `CHK(l2, l)
          chk(ottu_pkg::OFS_CTL, 8'hD0);
          wr(ottu_pkg::OFS_CAH, 8'h77);
        end
        u_cpu.drive(2'h3, wd(16'h3000, k), 1'b1, 8'h00);
      end
      rd(ottu_pkg::OFS_STS, h);
      `CHK({h[5], h[3:0]}, 5'h08)
      `CHK(brk_cnt, (b < 2) ? 1 : 0)
      if (b < 2) `CHK(brk_tag, (b == 1))
      chk(ottu_pkg::OFS_CTL, cvs[8*b +: 8] & 8'hBF);
      chk(ottu_pkg::OFS_CAH, 8'h20);
      // fifo read only after the run is over, high byte first
      for (int k = 0; k < 8; k++) begin
        rd(ottu_pkg::OFS_FH, h);
        rd(ottu_pkg::OFS_FH, l2);
        rd(ottu_pkg::OFS_FL, l);
        `CHK(h, l2)
        `CHK({l2, l}, wd(16'h3000, k))
      end
      // the comparator A hit that triggered the run stays flagged
      chk(ottu_pkg::OFS_STS, 8'h88);
    end
  endtask : t_trace

  task automatic t_event();
    logic [7:0] h;
    logic [7:0] l;
    wr(ottu_pkg::OFS_TRG, 8'h03);
    wr(ottu_pkg::OFS_CTL, 8'hC3);
    u_cpu.drive(2'h0, 16'h2010, 1'b0, 8'hEE);
    for (int k = 0; k < 8; k++)
      u_cpu.drive(2'h0, 16'h2010, 1'b1, 8'h40 + 8'(k));
    chk_run_active_flag(1'b0);
    for (int k = 0; k < 8; k++) begin
      rd(ottu_pkg::OFS_FH, h);
      rd(ottu_pkg::OFS_FL, l);
      `CHK({h, l}, {8'h00, 8'h40 + 8'(k)})
    end
  endtask : t_event

  task automatic t_prof();
    logic [7:0] h;
    logic [7:0] l;
    wr(ottu_pkg::OFS_CTL, 8'h80);
    for (int i = 0; i < 16; i++) begin
      u_cpu.drive(2'h1, wd(16'h4000, i), 1'b1, 8'h00);
      rd(ottu_pkg::OFS_FH, h);
      rd(ottu_pkg::OFS_FL, l);
      // first eight reads only prime the delay line
      if (i >= 8) `CHK({h, l}, wd(16'h4000, i - 8))
    end
  endtask : t_prof

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    rst_n      = 1'b0;
    reg_addr   = 4'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_wdata  = 8'h00;
    mcu_secure = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    t_regs();
    t_modes();
    t_dir();
    t_tag();
    t_trace();
    t_event();
    t_prof();
    final_report();
  end
endmodule : tb_top
